// ===== core/lpm_pkg.sv
package lpm_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] LPM_CTRL_OFS   = 8'h00;
    localparam logic [7:0] LPM_STATUS_OFS = 8'h04;
    localparam logic [7:0] LPM_VECTOR_OFS = 8'h08;
    // control register field positions
    localparam int LPM_OSC_RUN_BIT   = 0;
    localparam int LPM_SHORT_REC_BIT = 1;
    localparam int LPM_MON_OFF_BIT   = 2;
    localparam int LPM_TB_OFF_BIT    = 3;
    localparam int LPM_BRK_EN_BIT    = 4;
    localparam int LPM_CTRL_W        = 5;
    localparam logic [4:0] LPM_CTRL_RST = 5'h00;
    // status register field positions
    localparam int LPM_FLAG_BIT = 2;
    // stop recovery in crystal clock edges, loaded as count minus one
    localparam int LPM_REC_LONG  = 4096;
    localparam int LPM_REC_SHORT = 32;
    localparam logic [11:0] LPM_REC_LONG_LD  = 12'(LPM_REC_LONG - 1);
    localparam logic [11:0] LPM_REC_SHORT_LD = 12'(LPM_REC_SHORT - 1);
    localparam logic [11:0] LPM_REC_DONE     = 12'h000;
    // vector pair base addresses
    localparam logic [15:0] LPM_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] LPM_VEC_BRK   = 16'hFFFC;
    localparam logic [15:0] LPM_VEC_EXT   = 16'hFFFA;
    localparam logic [15:0] LPM_VEC_SPIRX = 16'hFFEA;
    localparam logic [15:0] LPM_VEC_SPITX = 16'hFFE8;
    localparam logic [15:0] LPM_VEC_SCIER = 16'hFFE6;
    localparam logic [15:0] LPM_VEC_SCIRX = 16'hFFE4;
    localparam logic [15:0] LPM_VEC_SCITX = 16'hFFE2;
    localparam logic [15:0] LPM_VEC_KBD   = 16'hFFE0;
    localparam logic [15:0] LPM_VEC_CONV  = 16'hFFDE;
    localparam logic [15:0] LPM_VEC_TB    = 16'hFFDC;
    // synchroniser reset level: pins idle high, monitor and crystal low
    localparam logic [11:0] LPM_SYNC_RST = 12'h3FF;
    // operating modes
    typedef enum logic [1:0] {
        LPM_RUN     = 2'b00,
        LPM_WAIT    = 2'b01,
        LPM_STOP    = 2'b10,
        LPM_RECOVER = 2'b11
    } lpm_mode_t;
    // on-chip interrupt requests, already gated by their own enables
    typedef struct packed {
        logic spi_tx;
        logic spi_rx;
        logic sci_tx;
        logic sci_rx;
        logic sci_err;
        logic conv_done;
        logic timebase;
        logic brk;
    } lpm_irq_t;
endpackage : lpm_pkg

// ===== core/lpm_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - wait stops processor clock, bus runs
// - stop halts processor; bus off unless enabled
// - monitor and timebase switch off in wait
// - converter runs in wait, wakes device
// - stop aborts conversion; resumes after exit
// - break active in wait, sets flag
// - serial peripheral uses transmit, receive vectors
// - async serial uses three vector pairs
// - conversion complete uses its vector pair
// - timebase interrupt uses its vector pair
// - stop exit restarts clocks, loads vector
// - reset pin low resets, reset vector
// - falling pin edge exits via pin vector
// - monitor trip resets through reset vector
// - break ends stop through break vector
// - timebase rollover wakes from stop periodically
// - recovery counter holds clocks 4096 crystal cycles
// - short recovery bit gives 32 cycles
module lpm_ctrl
    import lpm_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // processor core
    input  wire logic        wait_instr,
    input  wire logic        stop_instr,
    input  wire lpm_irq_t    irq_req,
    output logic             vector_load,
    output logic [15:0]      vector_addr,
    // pins and analog, asynchronous
    input  wire logic        rst_pin_n,
    input  wire logic        ext_irq_pin_n,
    input  wire logic [7:0]  kbd_pin_n,
    input  wire logic        monitor_trip_level,
    input  wire logic        crystal_clock,
    // clock gates and module controls
    output logic             cpu_clk_en,
    output logic             bus_clk_en,
    output logic             voltage_monitor_en,
    output logic             timebase_unit_en,
    output logic             converter_run,
    output logic             converter_abort,
    output logic             device_reset_req,
    output logic             break_in_wait_flag
);

    lpm_mode_t   mode_reg;         // current mode
    lpm_mode_t   mode_next;
    logic [4:0]  ctrl_reg;         // software configuration
    logic [11:0] sync1_reg;        // first synchroniser stage
    logic [11:0] sync2_reg;        // second stage, safe to read
    logic [11:0] sync3_reg;        // delayed copy for edge detection
    logic [11:0] rec_cnt_reg;      // stop recovery down counter
    logic [15:0] pend_vec_reg;     // vector held through recovery
    logic [15:0] vec_reg;          // vector presented to core
    logic        vload_reg;        // one-cycle load strobe
    logic        abort_reg;        // one-cycle abort strobe
    logic        flag_reg;         // break in wait status
    logic        rst_ev;           // reset pin or monitor trip
    logic        ext_fall;         // external pin falling edge
    logic        kbd_fall;         // any keypad falling edge
    logic        xtal_rise;        // crystal clock rising edge
    logic        stop_wake;        // any stop exit event
    logic        any_irq;          // any on-chip request
    logic [15:0] wake_vec;         // highest priority vector now
    logic        apb_wr;           // write access phase
    logic        apb_rd;           // read access phase
    logic        addr_ok;          // mapped address

    // two stages before any logic looks at a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= LPM_SYNC_RST;
            sync2_reg <= LPM_SYNC_RST;
            sync3_reg <= LPM_SYNC_RST;
        end else begin
            sync1_reg <= {crystal_clock, monitor_trip_level, kbd_pin_n,
                          ext_irq_pin_n, rst_pin_n};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // event decode, pin events all from the second stage onward
    always_comb begin
        rst_ev    = !sync2_reg[0] || sync2_reg[10];
        ext_fall  = sync3_reg[1] && !sync2_reg[1];
        kbd_fall  = |(sync3_reg[9:2] & ~sync2_reg[9:2]);
        xtal_rise = sync2_reg[11] && !sync3_reg[11];
        any_irq   = |irq_req;
        // stop wakes only on reset, pins, break and timebase
        stop_wake = rst_ev || ext_fall || kbd_fall ||
                    irq_req.brk || irq_req.timebase;
    end

    // vector priority: reset first, then break, pins, peripherals
    always_comb begin
        if (rst_ev) begin
            wake_vec = LPM_VEC_RESET;
        end else if (irq_req.brk) begin
            wake_vec = LPM_VEC_BRK;
        end else if (ext_fall) begin
            wake_vec = LPM_VEC_EXT;
        end else if (kbd_fall) begin
            wake_vec = LPM_VEC_KBD;
        end else if (irq_req.spi_tx) begin
            wake_vec = LPM_VEC_SPITX;
        end else if (irq_req.spi_rx) begin
            wake_vec = LPM_VEC_SPIRX;
        end else if (irq_req.sci_tx) begin
            wake_vec = LPM_VEC_SCITX;
        end else if (irq_req.sci_rx) begin
            wake_vec = LPM_VEC_SCIRX;
        end else if (irq_req.sci_err) begin
            wake_vec = LPM_VEC_SCIER;
        end else if (irq_req.conv_done) begin
            wake_vec = LPM_VEC_CONV;
        end else begin
            wake_vec = LPM_VEC_TB;
        end
    end

    // mode sequencing
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            LPM_RUN: begin
                if (stop_instr) begin
                    mode_next = LPM_STOP;
                end else if (wait_instr) begin
                    mode_next = LPM_WAIT;
                end
            end
            LPM_WAIT: begin
                // no recovery delay: oscillator never stopped
                if (rst_ev || any_irq || ext_fall || kbd_fall) begin
                    mode_next = LPM_RUN;
                end
            end
            LPM_STOP: begin
                if (stop_wake) begin
                    mode_next = LPM_RECOVER;
                end
            end
            default: begin
                if (xtal_rise && rec_cnt_reg == LPM_REC_DONE) begin
                    mode_next = LPM_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= LPM_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // recovery counter steps on crystal edges only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_cnt_reg <= LPM_REC_LONG_LD;
        end else if (mode_reg == LPM_STOP) begin
            // a crystal board must leave the short bit clear
            rec_cnt_reg <= ctrl_reg[LPM_SHORT_REC_BIT] ?
                           LPM_REC_SHORT_LD : LPM_REC_LONG_LD;
        end else if (mode_reg == LPM_RECOVER && xtal_rise &&
                     rec_cnt_reg != LPM_REC_DONE) begin
            rec_cnt_reg <= rec_cnt_reg - 12'h001;
        end
    end

    // vector capture and load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_vec_reg <= LPM_VEC_RESET;
            vec_reg      <= LPM_VEC_RESET;
            vload_reg    <= 1'b0;
        end else begin
            vload_reg <= 1'b0;
            if (mode_reg == LPM_STOP && stop_wake) begin
                pend_vec_reg <= wake_vec;
            end
            if (mode_reg == LPM_RECOVER && mode_next == LPM_RUN) begin
                vec_reg   <= pend_vec_reg;
                vload_reg <= 1'b1;
            end else if (mode_reg == LPM_WAIT && mode_next == LPM_RUN) begin
                vec_reg   <= wake_vec;
                vload_reg <= 1'b1;
            end
        end
    end

    // converter abort strobe on stop entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_reg <= 1'b0;
        end else begin
            abort_reg <= mode_reg == LPM_RUN && stop_instr;
        end
    end

    // break in wait flag, set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (mode_reg == LPM_WAIT && irq_req.brk &&
                     ctrl_reg[LPM_BRK_EN_BIT]) begin
            flag_reg <= 1'b1;
        end else if (apb_wr && paddr == LPM_STATUS_OFS &&
                     pwdata[LPM_FLAG_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    // apb decode; zero wait states, unmapped answers with an error
    always_comb begin
        apb_wr  = psel && penable && pwrite;
        apb_rd  = psel && penable && !pwrite;
        addr_ok = 1'b0;
        if (paddr == LPM_CTRL_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == LPM_STATUS_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == LPM_VECTOR_OFS) begin
            addr_ok = 1'b1;
        end
    end

    // configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= LPM_CTRL_RST;
        end else if (apb_wr && paddr == LPM_CTRL_OFS) begin
            ctrl_reg <= pwdata[LPM_CTRL_W-1:0];
        end
    end

    // read data registered so the bus sees flop outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == LPM_CTRL_OFS) begin
                prdata <= {27'h0000000, ctrl_reg};
            end else if (paddr == LPM_STATUS_OFS) begin
                prdata <= {29'h00000000, flag_reg, mode_reg};
            end else if (paddr == LPM_VECTOR_OFS) begin
                prdata <= {16'h0000, vec_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // clock gates and module enables
    always_comb begin
        cpu_clk_en = mode_reg == LPM_RUN;
        bus_clk_en = mode_reg == LPM_RUN || mode_reg == LPM_WAIT ||
                     (mode_reg == LPM_STOP &&
                      ctrl_reg[LPM_OSC_RUN_BIT]);
        voltage_monitor_en = !(mode_reg == LPM_WAIT &&
                               ctrl_reg[LPM_MON_OFF_BIT]);
        timebase_unit_en   = !(mode_reg == LPM_WAIT &&
                               ctrl_reg[LPM_TB_OFF_BIT]);
        converter_run = mode_reg == LPM_RUN ||
                        mode_reg == LPM_WAIT;
    end

    assign converter_abort    = abort_reg;
    assign vector_load        = vload_reg;
    assign vector_addr        = vec_reg;
    assign device_reset_req   = rst_ev;
    assign break_in_wait_flag = flag_reg;

    // checks
    a_wait_cpu_off: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_WAIT |-> !cpu_clk_en && bus_clk_en)
        else $error("wait mode clock gating wrong");
    a_stop_bus_gate: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_STOP |-> bus_clk_en ==
        ctrl_reg[LPM_OSC_RUN_BIT])
        else $error("stop bus clock gate wrong");
    a_stop_entry_abort: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_reg == LPM_RUN && stop_instr |=> converter_abort &&
        mode_reg == LPM_STOP && !converter_run)
        else $error("stop entry did not abort conversion");
    a_wait_wake_vec: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_WAIT && irq_req.conv_done && !rst_ev &&
        !ext_fall && !kbd_fall && !irq_req.brk && !irq_req.spi_tx &&
        !irq_req.spi_rx && !irq_req.sci_tx && !irq_req.sci_rx &&
        !irq_req.sci_err |=> vector_load &&
        vector_addr == LPM_VEC_CONV && cpu_clk_en)
        else $error("wait wake vector wrong");
    a_rec_short_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_STOP && mode_next == LPM_RECOVER &&
        ctrl_reg[LPM_SHORT_REC_BIT] |=>
        rec_cnt_reg == LPM_REC_SHORT_LD)
        else $error("short recovery count not loaded");
    a_rec_hold_clk: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_RECOVER && rec_cnt_reg != LPM_REC_DONE |=>
        !cpu_clk_en && !bus_clk_en)
        else $error("clocks ran during recovery");
    a_rec_exit_vec: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_RECOVER && mode_next == LPM_RUN |=>
        vector_load && vector_addr == $past(pend_vec_reg))
        else $error("stop exit vector not loaded");
    a_rst_vec_stop: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_STOP && rst_ev |=>
        pend_vec_reg == LPM_VEC_RESET && device_reset_req)
        else $error("reset did not pick reset vector");
    a_brk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_WAIT && irq_req.brk &&
        ctrl_reg[LPM_BRK_EN_BIT] |=> break_in_wait_flag)
        else $error("break in wait flag not set");
    a_wait_mon_off: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_WAIT && ctrl_reg[LPM_MON_OFF_BIT] |->
        !voltage_monitor_en)
        else $error("monitor not gated in wait");
    c_wait_wake: cover property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_WAIT ##1 mode_reg == LPM_RUN);
    c_stop_recover: cover property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_RECOVER ##1 mode_reg == LPM_RUN);
    c_tb_wake: cover property (@(posedge pclk) disable iff (!presetn)
        mode_reg == LPM_STOP && irq_req.timebase && !rst_ev);
    c_flag_set: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(break_in_wait_flag));

endmodule : lpm_ctrl

// ===== testbench/lpm_core_model.sv
`timescale 1ns/100ps
// processor core and peripheral request sources facing the controller
module lpm_core_model
    import lpm_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // instruction pulses and request levels
    output logic      wait_instr,
    output logic      stop_instr,
    output lpm_irq_t  irq_req,
    // vector fetch from the controller
    input  wire logic vector_load
);
    logic stop_seen;   // a stop was issued since the last fetch
    logic discard_reg; // first conversion result after stop is unusable

    initial begin
        wait_instr = 1'b0;
        stop_instr = 1'b0;
        irq_req = '0;
        stop_seen = 1'b0;
        discard_reg = 1'b0;
    end

    // one-cycle instruction pulse; software is assumed to have powered
    // the converter down when it must not wake the part
    task automatic instr(input logic stop);
        stop_instr <= stop;
        wait_instr <= !stop;
        stop_seen <= stop_seen | stop;
        @(posedge pclk);
        stop_instr <= 1'b0;
        wait_instr <= 1'b0;
    endtask : instr

    // a request stays a level until the handler is entered
    task automatic raise(input int idx);
        irq_req[idx] <= 1'b1;
    endtask : raise

    // the vector fetch acknowledges every source, like a handler entry
    always @(posedge pclk) begin
        if (!presetn) begin
            irq_req <= '0;
        end else if (vector_load === 1'b1) begin
            irq_req <= '0;
            discard_reg <= stop_seen; // skip first conversion
            stop_seen <= 1'b0;
        end
    end
endmodule : lpm_core_model

// ===== testbench/lpm_ctrl_tb_top.sv
`timescale 1ns/100ps
// self-checking bench for the low-power mode controller
module lpm_ctrl_tb_top
    import lpm_pkg::*;
;
    // one wake case: mode, control word, source, vector, crystal edges
    typedef struct {
        logic st; logic [4:0] ctrl; int src; logic [15:0] vec; int edg;
    } lpm_row_t;

    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, wait_instr, stop_instr;
    logic [7:0]  paddr = 8'h00, kbd_pin_n = 8'hFF;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    lpm_irq_t    irq_req;
    logic [15:0] vector_addr;
    logic        rst_pin_n = 1'b1, ext_irq_pin_n = 1'b1, err, xtal_on = 0;
    logic        monitor_trip_level = 1'b0, crystal_clock = 1'b0;
    logic        vector_load, cpu_clk_en, bus_clk_en, voltage_monitor_en;
    logic        timebase_unit_en, converter_run, converter_abort;
    logic        device_reset_req, break_in_wait_flag;
    int          miscompares = 0, checked = 0, edges = 0, aborts = 0;

    // sources 0..7 are request bits, 8 ext pin, 9 key pin, 10 reset pin,
    // 11 supply monitor
    lpm_row_t rows[15] = '{
        '{1'b0, 5'h1C, 7, 16'hFFE8, 0},
        '{1'b0, 5'h1C, 6, 16'hFFEA, 0},
        '{1'b0, 5'h1C, 5, 16'hFFE2, 0},
        '{1'b0, 5'h1C, 4, 16'hFFE4, 0},
        '{1'b0, 5'h1C, 3, 16'hFFE6, 0},
        '{1'b0, 5'h00, 2, 16'hFFDE, 0},
        '{1'b0, 5'h10, 1, 16'hFFDC, 0},
        '{1'b0, 5'h10, 0, 16'hFFFC, 0},
        '{1'b0, 5'h00, 8, 16'hFFFA, 0},
        '{1'b1, 5'h02, 8, 16'hFFFA, 32},
        '{1'b1, 5'h02, 10, 16'hFFFE, 32},
        '{1'b1, 5'h02, 11, 16'hFFFE, 32},
        '{1'b1, 5'h02, 0, 16'hFFFC, 32},
        '{1'b1, 5'h03, 1, 16'hFFDC, 32},
        '{1'b1, 5'h01, 9, 16'hFFE0, 4096}
    };

    lpm_ctrl u_lpm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_instr(wait_instr), .stop_instr(stop_instr), .irq_req(irq_req),
        .vector_load(vector_load), .vector_addr(vector_addr),
        .rst_pin_n(rst_pin_n), .ext_irq_pin_n(ext_irq_pin_n),
        .kbd_pin_n(kbd_pin_n), .monitor_trip_level(monitor_trip_level),
        .crystal_clock(crystal_clock), .cpu_clk_en(cpu_clk_en),
        .bus_clk_en(bus_clk_en), .voltage_monitor_en(voltage_monitor_en),
        .timebase_unit_en(timebase_unit_en), .converter_run(converter_run),
        .converter_abort(converter_abort),
        .device_reset_req(device_reset_req),
        .break_in_wait_flag(break_in_wait_flag));

    lpm_core_model u_lpm_core_model (.pclk(pclk), .presetn(presetn),
        .wait_instr(wait_instr), .stop_instr(stop_instr),
        .irq_req(irq_req), .vector_load(vector_load));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // crystal toggles every 4 pclk, only while a recovery is timed
    initial begin : xtal
        int ph;
        ph = 0;
        forever begin
            @(posedge pclk);
            if (xtal_on) begin
                ph = ph + 1;
                if (ph == 4) begin
                    ph = 0;
                    if (crystal_clock === 1'b0) edges = edges + 1;
                    crystal_clock <= ~crystal_clock;
                end
            end
        end
    end

    // count converter abort pulses
    always @(posedge pclk) begin
        if (converter_abort === 1'b1) aborts <= aborts + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        // a slave that never answers is a failure, not a silent skip
        if (pready !== 1'b1) miscompares++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // bounded wait for the vector fetch pulse
    task automatic wait_load(input int lim);
        int n;
        n = 0;
        while (vector_load !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_load

    // enter a low-power mode, wake it from one source, check the exit
    task automatic run_row(input lpm_row_t r);
        int n;
        apb(1'b1, LPM_CTRL_OFS, 32'(r.ctrl));
        edges = 0;
        aborts = 0;
        u_lpm_core_model.instr(r.st);
        repeat (2) @(posedge pclk);
        chk(cpu_clk_en, 0);
        chk(bus_clk_en, r.st ? r.ctrl[LPM_OSC_RUN_BIT] : 1'b1);
        chk(converter_run, !r.st);
        if (!r.st) begin
            chk(voltage_monitor_en, !r.ctrl[LPM_MON_OFF_BIT]);
            chk(timebase_unit_en, !r.ctrl[LPM_TB_OFF_BIT]);
        end
        // pins wake both modes, so the source is driven the same way
        case (r.src)
            8: ext_irq_pin_n <= 1'b0;
            9: kbd_pin_n <= 8'hF7;
            10: rst_pin_n <= 1'b0;
            11: monitor_trip_level <= 1'b1;
            default: u_lpm_core_model.raise(r.src);
        endcase
        if (!r.st) begin
            wait_load(20);
        end else begin
            repeat (5) @(posedge pclk);
            chk(device_reset_req, r.src >= 10);
        end
        ext_irq_pin_n <= 1'b1;
        kbd_pin_n <= 8'hFF;
        rst_pin_n <= 1'b1;
        monitor_trip_level <= 1'b0;
        if (r.st) begin
            n = 0;
            // crystal stays still until the part is seen recovering
            do begin
                apb(1'b0, LPM_STATUS_OFS, 32'h0);
                n++;
            end while (rd[1:0] !== 2'b11 && n < 20);
            xtal_on = 1'b1;
            wait_load(40000);
            xtal_on = 1'b0;
        end
        chk(vector_load, 1);
        chk(vector_addr, r.vec);
        chk(edges, r.edg);
        chk({cpu_clk_en, bus_clk_en, converter_run}, 3'b111);
        chk(aborts, r.st);
        @(posedge pclk);
    endtask : run_row

    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // watchdog: the run needs about 35k cycles
    initial begin
        #600000;
        miscompares++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LPM_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, LPM_VECTOR_OFS, 32'h0);
        chk(rd, 32'h0000FFFE);
        chk({cpu_clk_en, bus_clk_en, converter_run}, 3'b111);
        foreach (rows[i]) begin
            run_row(rows[i]);
            if (i == 7) begin
                apb(1'b0, LPM_STATUS_OFS, 32'h0);
                chk(rd[LPM_FLAG_BIT], 1);
                chk(break_in_wait_flag, 1);
                apb(1'b1, LPM_STATUS_OFS, 32'h4);
                apb(1'b0, LPM_STATUS_OFS, 32'h0);
                chk(rd[LPM_FLAG_BIT], 0);
                chk(break_in_wait_flag, 0);
            end
        end
        // unmapped write is refused, control word survives
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk(err, 1);
        apb(1'b1, LPM_VECTOR_OFS, 32'h0);
        apb(1'b0, LPM_VECTOR_OFS, 32'h0);
        chk(rd, 32'h0000FFE0);
        apb(1'b0, LPM_CTRL_OFS, 32'h0);
        chk(rd, 32'h01);
        close_out();
    end
endmodule : lpm_ctrl_tb_top
